// ---- logic/cmp_pkg.sv ----
package cmp_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and timing.
	localparam int CLK_HZ = 25_000_000;
	localparam int CLK_PERIOD_NS = 40;
	localparam int OSC_HZ = 67_000;
	localparam int OSC_PERIOD_CYC = CLK_HZ / OSC_HZ;
	localparam int JIT_PCT = 4;
	localparam int JIT_AMP_CYC = OSC_PERIOD_CYC * JIT_PCT / 100;
	localparam int JIT_PERIOD_MS = 4;
	localparam int JIT_PERIOD_CYC = JIT_PERIOD_MS * (CLK_HZ / 1000);
	localparam int DUTY_MAX_NUM = 3;
	localparam int DUTY_MAX_SHIFT = 2;
	localparam int LEB_NS = 220;
	localparam int LEB_CYC = (LEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MIN_ON_NS = 156;
	localparam int MIN_ON_CYC = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SS_STEPS = 32;
	localparam int SS_STEP_BITS = 5;
	localparam int SS_STEP_US = 600;
	localparam int SS_STEP_CYC = SS_STEP_US * (CLK_HZ / 1_000_000);
	localparam int SS_TIME_MS = 20;
	localparam int SS_TIME_CYC = SS_TIME_MS * (CLK_HZ / 1000);
	localparam int BLANK_MS = 20;
	localparam int BLANK_CYC = BLANK_MS * (CLK_HZ / 1000);

	////////////////////////////////////////////////////////////////////////////////
	// Widths.
	localparam int OSC_W = 10;
	localparam int CNT_W = 20;

	////////////////////////////////////////////////////////////////////////////////
	// Types.
	typedef enum logic [4:0] {
		ST_OFF = 5'h01,
		ST_SOFT = 5'h02,
		ST_RUN = 5'h04,
		ST_BURST = 5'h08,
		ST_RESTART = 5'h10
	} cmp_mode_t;

	typedef struct packed {
		logic supply_ok;
		logic feedback_trip;
		logic peak_trip;
		logic burst_trip;
		logic feedback_low;
		logic feedback_high;
		logic blank_ext_done;
	} cmp_sense_t;

	typedef struct packed {
		logic softstart_active;
		logic normal_active;
		logic burst_active;
		logic restart_active;
		logic blank_release;
	} cmp_status_t;

	typedef struct packed {
		cmp_mode_t mode;
		logic gate;
		logic [OSC_W-1:0] osc_cnt;
		logic [OSC_W-1:0] on_cnt;
		logic [OSC_W-1:0] jit_off;
		logic jit_down;
		logic [CNT_W-1:0] jit_tmr;
		logic [SS_STEP_BITS-1:0] ss_step;
		logic [CNT_W-1:0] ss_step_tmr;
		logic [CNT_W-1:0] ss_tmr;
		logic [CNT_W-1:0] blank_cnt;
		cmp_status_t status;
	} cmp_core_state_t;

	localparam cmp_core_state_t CORE_RESET = '{mode: ST_OFF, default: '0};

endpackage

// ---- logic/cmp_sync.sv ----
`timescale 1ns/1ps
module cmp_sync #(
	parameter int WIDTH = 1
) (
	// Clock, reset and freeze.
	input wire logic clock,
	input wire logic reset,
	input wire logic enable,
	// Asynchronous levels in, synchronised levels out.
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} cmp_sync_state_t;

	cmp_sync_state_t state;
	cmp_sync_state_t next_state;

	// The first stage feeds only the second stage.
	always_comb begin
		next_state = state;
		if (enable) begin
			next_state.meta = async_in;
			next_state.stable = state.meta;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign sync_out = state.stable;

endmodule

// ---- logic/cmp_core.sv ----
`timescale 1ns/1ps
module cmp_core #(
	parameter int SS_STEP_CYC = cmp_pkg::SS_STEP_CYC,
	parameter int SS_TIME_CYC = cmp_pkg::SS_TIME_CYC,
	parameter int BLANK_CYC = cmp_pkg::BLANK_CYC,
	parameter int JIT_PERIOD_CYC = cmp_pkg::JIT_PERIOD_CYC
) (
	// Clock, reset and freeze.
	input wire logic clock,
	input wire logic reset,
	input wire logic enable,
	// Comparator decisions from the analog front end, asynchronous.
	input wire cmp_pkg::cmp_sense_t sense,
	// Power switch driver.
	output logic gate_drive,
	// Operating mode flags.
	output cmp_pkg::cmp_status_t status
);

	localparam int OW = cmp_pkg::OSC_W;
	localparam int CW = cmp_pkg::CNT_W;
	localparam int SW = cmp_pkg::SS_STEP_BITS;
	localparam int JIT_STEP_CYC = JIT_PERIOD_CYC / (4 * cmp_pkg::JIT_AMP_CYC);

	localparam logic [OW-1:0] NOM_PERIOD = OW'(cmp_pkg::OSC_PERIOD_CYC);
	localparam logic [OW-1:0] JIT_AMP = OW'(cmp_pkg::JIT_AMP_CYC);
	localparam logic [OW-1:0] JIT_SPAN = OW'(2 * cmp_pkg::JIT_AMP_CYC);
	localparam logic [OW-1:0] LEB_LIM = OW'(cmp_pkg::LEB_CYC);
	localparam logic [OW-1:0] MIN_ON_LIM = OW'(cmp_pkg::MIN_ON_CYC);
	localparam logic [SW-1:0] SS_LAST = SW'(cmp_pkg::SS_STEPS - 1);
	localparam logic [CW-1:0] SS_STEP_LAST = CW'(SS_STEP_CYC - 1);
	localparam logic [CW-1:0] SS_TIME_LAST = CW'(SS_TIME_CYC - 1);
	localparam logic [CW-1:0] BLANK_LAST = CW'(BLANK_CYC - 1);
	localparam logic [CW-1:0] JIT_STEP_LAST = CW'(JIT_STEP_CYC - 1);

	////////////////////////////////////////////////////////////////////////////////
	// Synchronised comparator decisions.

	logic [$bits(cmp_pkg::cmp_sense_t)-1:0] sense_sync;
	cmp_pkg::cmp_sense_t s;

	cmp_sync #(
		.WIDTH($bits(cmp_pkg::cmp_sense_t))
	) u_sense_sync (
		.clock(clock),
		.reset(reset),
		.enable(enable),
		.async_in(sense),
		.sync_out(sense_sync)
	);

	assign s = cmp_pkg::cmp_sense_t'(sense_sync);

	////////////////////////////////////////////////////////////////////////////////
	// State.

	cmp_pkg::cmp_core_state_t state;
	cmp_pkg::cmp_core_state_t next_state;

	function automatic logic is_switching(input cmp_pkg::cmp_mode_t mode);
		is_switching = (mode == cmp_pkg::ST_SOFT) || (mode == cmp_pkg::ST_RUN) ||
			(mode == cmp_pkg::ST_BURST);
	endfunction

	function automatic logic is_normal(input cmp_pkg::cmp_mode_t mode);
		is_normal = (mode == cmp_pkg::ST_RUN) || (mode == cmp_pkg::ST_BURST);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Period and on-time limits of the present cycle.

	logic [OW-1:0] period;
	logic [OW+1:0] max_on_prod;
	logic [OW-1:0] max_on;
	logic [OW+SW-1:0] ss_prod;
	logic [OW-1:0] ss_limit;

	// Jitter moves the period only once soft start is over.
	assign period = is_normal(state.mode) ?
		OW'(NOM_PERIOD - JIT_AMP + state.jit_off) : NOM_PERIOD;

	// The on-time window is three quarters of the period.
	assign max_on_prod = (OW+2)'(period) * (OW+2)'(cmp_pkg::DUTY_MAX_NUM);
	assign max_on = OW'(max_on_prod >> cmp_pkg::DUTY_MAX_SHIFT);

	// The soft-start limit scales the window by step over 32; step zero allows none.
	assign ss_prod = (OW+SW)'(max_on) * (OW+SW)'(state.ss_step);
	assign ss_limit = OW'(ss_prod >> SW);

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	logic osc_wrap;
	logic past_blank;
	logic duty_end;
	logic fb_end;
	logic peak_end;
	logic burst_end;
	logic soft_end;
	logic may_set;

	always_comb begin
		next_state = state;
		osc_wrap = 1'b0;
		past_blank = 1'b0;
		duty_end = 1'b0;
		fb_end = 1'b0;
		peak_end = 1'b0;
		burst_end = 1'b0;
		soft_end = 1'b0;
		may_set = 1'b0;

		// Mode sequencing.
		case (state.mode)
			cmp_pkg::ST_OFF: begin
				next_state.ss_step = '0;
				next_state.ss_step_tmr = '0;
				next_state.ss_tmr = '0;
				next_state.blank_cnt = '0;
				if (s.supply_ok) begin
					next_state.mode = cmp_pkg::ST_SOFT;
				end
			end
			cmp_pkg::ST_SOFT: begin
				if (state.ss_step_tmr == SS_STEP_LAST) begin
					next_state.ss_step_tmr = '0;
					if (state.ss_step != SS_LAST) begin
						next_state.ss_step = SW'(state.ss_step + 1'b1);
					end
				end else begin
					next_state.ss_step_tmr = CW'(state.ss_step_tmr + 1'b1);
				end
				if (state.ss_tmr == SS_TIME_LAST) begin
					next_state.mode = cmp_pkg::ST_RUN;
					next_state.ss_tmr = '0;
				end else begin
					next_state.ss_tmr = CW'(state.ss_tmr + 1'b1);
				end
			end
			cmp_pkg::ST_RUN: begin
				if (s.feedback_low || s.feedback_high) begin
					if (state.blank_cnt != BLANK_LAST) begin
						next_state.blank_cnt = CW'(state.blank_cnt + 1'b1);
					end
				end else begin
					next_state.blank_cnt = '0;
				end
				if (s.feedback_low && (state.blank_cnt == BLANK_LAST)) begin
					next_state.mode = cmp_pkg::ST_BURST;
					next_state.blank_cnt = '0;
				end
				if (s.feedback_high && state.status.blank_release && s.blank_ext_done) begin
					next_state.mode = cmp_pkg::ST_RESTART;
				end
			end
			cmp_pkg::ST_BURST: begin
				next_state.blank_cnt = '0;
				if (s.feedback_high) begin
					next_state.mode = cmp_pkg::ST_RUN;
				end
			end
			cmp_pkg::ST_RESTART: begin
				next_state.blank_cnt = '0;
			end
			default: begin
				next_state.mode = cmp_pkg::ST_OFF;
			end
		endcase

		// Losing the supply stops everything and rewinds soft start.
		if (!s.supply_ok) begin
			next_state.mode = cmp_pkg::ST_OFF;
			next_state.ss_step = '0;
			next_state.ss_step_tmr = '0;
			next_state.ss_tmr = '0;
			next_state.blank_cnt = '0;
		end

		// Triangular jitter sweep, centred while not in normal operation.
		if (is_normal(state.mode)) begin
			if (state.jit_tmr == JIT_STEP_LAST) begin
				next_state.jit_tmr = '0;
				if (state.jit_down) begin
					next_state.jit_off = OW'(state.jit_off - 1'b1);
					if (state.jit_off == OW'(1)) begin
						next_state.jit_down = 1'b0;
					end
				end else begin
					next_state.jit_off = OW'(state.jit_off + 1'b1);
					if (state.jit_off == OW'(JIT_SPAN - 1'b1)) begin
						next_state.jit_down = 1'b1;
					end
				end
			end else begin
				next_state.jit_tmr = CW'(state.jit_tmr + 1'b1);
			end
		end else begin
			next_state.jit_tmr = '0;
			next_state.jit_off = JIT_AMP;
			next_state.jit_down = 1'b0;
		end

		// Oscillator and switching latch.
		osc_wrap = state.osc_cnt >= OW'(period - 1'b1);
		past_blank = state.on_cnt >= LEB_LIM;
		duty_end = state.on_cnt >= OW'(max_on - 1'b1);
		fb_end = s.feedback_trip && past_blank && (state.on_cnt >= MIN_ON_LIM);
		peak_end = s.peak_trip && past_blank;
		burst_end = (state.mode == cmp_pkg::ST_BURST) && s.burst_trip && past_blank;
		soft_end = (state.mode == cmp_pkg::ST_SOFT) &&
			(state.on_cnt >= OW'(ss_limit - 1'b1));
		may_set = !((state.mode == cmp_pkg::ST_SOFT) && (ss_limit == '0));

		if (is_switching(state.mode) && is_switching(next_state.mode)) begin
			next_state.osc_cnt = osc_wrap ? '0 : OW'(state.osc_cnt + 1'b1);
			if (osc_wrap) begin
				next_state.gate = may_set;
				next_state.on_cnt = '0;
			end else if (state.gate) begin
				next_state.on_cnt = OW'(state.on_cnt + 1'b1);
				if (duty_end || fb_end || peak_end || burst_end || soft_end) begin
					next_state.gate = 1'b0;
				end
			end
		end else begin
			next_state.osc_cnt = '0;
			next_state.on_cnt = '0;
			next_state.gate = 1'b0;
		end

		// Flags follow the mode being entered.
		next_state.status.softstart_active = next_state.mode == cmp_pkg::ST_SOFT;
		next_state.status.normal_active = next_state.mode == cmp_pkg::ST_RUN;
		next_state.status.burst_active = next_state.mode == cmp_pkg::ST_BURST;
		next_state.status.restart_active = next_state.mode == cmp_pkg::ST_RESTART;
		// The capacitor charge is released once overload has persisted 20 ms.
		next_state.status.blank_release = (next_state.mode == cmp_pkg::ST_RUN) &&
			s.feedback_high && (next_state.blank_cnt == BLANK_LAST);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state <= cmp_pkg::CORE_RESET;
		end else if (enable) begin
			state <= next_state;
		end
	end

	assign gate_drive = state.gate;
	assign status = state.status;

endmodule

// ---- verif/cmp_core_monitor.sv ----
`timescale 1ns/1ps
module cmp_core_monitor #(
	parameter int SS_STEP_CYC = 1,
	parameter int SS_TIME_CYC = 1,
	parameter int BLANK_CYC = 1,
	parameter int JIT_PERIOD_CYC = 1
) (
	// Clock, reset and freeze.
	input wire logic clock,
	input wire logic reset,
	input wire logic enable,
	// Core ports.
	input wire cmp_pkg::cmp_sense_t sense,
	input wire logic gate_drive,
	input wire cmp_pkg::cmp_status_t status
);
	int on_run;
	int ss_run;
	int since;
	logic gd;
	cmp_pkg::cmp_status_t last;
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////////////////////
	// Counters of gate on-time, soft-start length and time between turn-ons.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			on_run <= 0;
			ss_run <= 0;
			since <= 0;
			gd <= 1'b0;
			last <= '0;
		end else if (enable) begin
			on_run <= gate_drive ? on_run + 1 : 0;
			ss_run <= status.softstart_active ? ss_run + 1 : 0;
			gd <= gate_drive;
			since <= (gate_drive && !gd) ? 1 : since + 1;
			if (gate_drive && !gd)
				last <= status;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	lockout_off_a: assert property ((!sense.supply_ok && enable)[*4] |=>
		!gate_drive && status == 5'h00) else $error("gate or mode on below lockout");
	soft_entry_a: assert property ((sense.supply_ok && enable)[*5] |->
		status != 5'h00) else $error("no start after supply ok");
	edge_blank_a: assert property ($rose(gate_drive) && sense.supply_ok &&
		!sense.blank_ext_done |=> gate_drive[*4]) else $error("pulse cut in blanking");
	max_duty_a: assert property (gate_drive |-> on_run <= 291)
		else $error("on-time beyond duty limit");
	fb_term_a: assert property ((sense.feedback_trip && on_run > 8 && enable)[*4]
		|=> !gate_drive) else $error("feedback did not end pulse");
	peak_term_a: assert property ((sense.peak_trip && on_run > 8 && enable)[*4]
		|=> !gate_drive) else $error("peak limit did not end pulse");
	burst_term_a: assert property ((sense.burst_trip && status.burst_active &&
		on_run > 8 && enable)[*4] |=> !gate_drive) else $error("burst limit ignored");
	soft_len_a: assert property ($fell(status.softstart_active) && status.normal_active
		|-> ss_run inside {[SS_TIME_CYC-2:SS_TIME_CYC+2]}) else $error("soft start length");
	soft_period_a: assert property ($rose(gate_drive) && status.softstart_active &&
		last == status |-> since % cmp_pkg::OSC_PERIOD_CYC == 0) else $error("soft period");
	run_period_a: assert property ($rose(gate_drive) && status.normal_active &&
		last == status |-> since inside {[359:387]}) else $error("run period out of range");
	freeze_hold_a: assert property (!enable |=> $stable(gate_drive) && $stable(status))
		else $error("state moved while enable low");
	cover property ($rose(status.normal_active));
	cover property ($rose(status.burst_active));
	cover property ($rose(status.restart_active));
endmodule

bind cmp_core cmp_core_monitor #(.SS_STEP_CYC(SS_STEP_CYC), .SS_TIME_CYC(SS_TIME_CYC),
	.BLANK_CYC(BLANK_CYC), .JIT_PERIOD_CYC(JIT_PERIOD_CYC)) cmp_core_monitor_inst (
	.clock(clock), .reset(reset), .enable(enable), .sense(sense),
	.gate_drive(gate_drive), .status(status));

// ---- verif/cmp_front.sv ----
`timescale 1ns/1ps
module cmp_front (
	// Clock and gate from the core.
	input wire logic clock,
	input wire logic gate_drive,
	// Trip points in cycles of on-time, and slow levels.
	input wire logic [9:0] fb_lvl,
	input wire logic [9:0] pk_lvl,
	input wire logic [9:0] bu_lvl,
	input wire logic [3:0] slow,
	// Comparator decisions to the core.
	output cmp_pkg::cmp_sense_t sense
);
	int ramp;
	initial begin
		ramp = 0;
		sense = '0;
	end
	// The current ramp grows while the switch is on and collapses when it is off.
	always @(posedge clock) begin
		ramp <= gate_drive ? ramp + 1 : 0;
		sense.feedback_trip <= gate_drive && ramp >= fb_lvl;
		sense.peak_trip <= gate_drive && ramp >= pk_lvl;
		sense.burst_trip <= gate_drive && ramp >= bu_lvl;
		sense.supply_ok <= slow[3];
		sense.feedback_low <= slow[2];
		sense.feedback_high <= slow[1];
		sense.blank_ext_done <= slow[0];
	end
endmodule

// ---- verif/current_mode_pwm_softstart_control_test.sv ----
`timescale 1ns/1ps
module current_mode_pwm_softstart_control_test;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic enable = 1'b1;
	logic [9:0] fb_lvl = 10'h3FF;
	logic [9:0] pk_lvl = 10'h3FF;
	logic [9:0] bu_lvl = 10'h3FF;
	logic [3:0] slow = 4'h0;
	cmp_pkg::cmp_sense_t sense;
	cmp_pkg::cmp_status_t status;
	logic gate_drive;
	int errors = 0;
	int total_checks = 0;
	always #20 clock = ~clock;
	cmp_core #(.SS_STEP_CYC(400), .SS_TIME_CYC(13000), .BLANK_CYC(50),
		.JIT_PERIOD_CYC(560)) cmp_core_inst (.clock(clock), .reset(reset),
		.enable(enable), .sense(sense), .gate_drive(gate_drive), .status(status));
	cmp_front cmp_front_inst (.clock(clock), .gate_drive(gate_drive), .fb_lvl(fb_lvl),
		.pk_lvl(pk_lvl), .bu_lvl(bu_lvl), .slow(slow), .sense(sense));
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic tick();
		@(posedge clock);
		#1;
	endtask
	task automatic waitst(input int b);
		int i;
		for (i = 0; i < 20000 && status[b] !== 1'b1; i++)
			tick();
		chk(status[b], 1'b1);
		if (i == 20000)
			end_of_test();
	endtask
	// Counts the cycles of the next whole gate pulse.
	task automatic meas(output int w);
		int i;
		w = 0;
		for (i = 0; i < 2000 && gate_drive !== 1'b0; i++)
			tick();
		for (i = 0; i < 2000 && gate_drive !== 1'b1; i++)
			tick();
		for (; i < 2000 && gate_drive === 1'b1; i++) begin
			tick();
			w++;
		end
		if (i == 2000) begin
			chk(0, 1);
			end_of_test();
		end
	endtask
	function automatic logic near(input int w, input int e);
		return w >= e - 1 && w <= e + 1;
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int w;
		int p;
		int k;
		int m;
		int lv[$];
		k = $urandom(43456);
		repeat (10) @(posedge clock);
		chk({gate_drive, status}, 6'h00);
		reset <= 1'b0;
		@(posedge clock);
		slow <= 4'h8;
		waitst(4);
		$display("test reset and start done");
		p = 0;
		meas(w);
		chk(w <= 10, 1);
		for (k = 0; k < 40 && status[4] === 1'b1; k++) begin
			chk(w >= p && w <= 272, 1);
			p = w;
			meas(w);
		end
		waitst(3);
		meas(w);
		chk(w >= 269 && w <= 291, 1);
		$display("test soft start done");
		for (k = 0; k < 16; k++)
			lv.push_back(10 + $urandom % 150);
		for (m = 0; m < 2; m++) begin
			for (k = 0; k < 8; k++) begin
				@(posedge clock);
				if (m == 0)
					fb_lvl <= lv[0];
				else
					pk_lvl <= lv[0];
				meas(w);
				meas(w);
				chk(near(w, lv.pop_front() + 3), 1);
			end
			@(posedge clock);
			fb_lvl <= 10'h3FF;
			pk_lvl <= 10'h3FF;
		end
		@(posedge clock);
		pk_lvl <= 10'h000;
		meas(w);
		meas(w);
		chk(w >= 6 && w <= 10, 1);
		@(posedge clock);
		pk_lvl <= 10'h3FF;
		$display("test terminations done");
		// A low enable must hold the gate and every mode flag where they stand.
		@(posedge clock);
		enable <= 1'b0;
		tick();
		p = {gate_drive, status};
		repeat (20) tick();
		chk({gate_drive, status}, p);
		@(posedge clock);
		enable <= 1'b1;
		$display("test clock enable done");
		@(posedge clock);
		slow <= 4'hC;
		waitst(2);
		@(posedge clock);
		bu_lvl <= 10'd20;
		meas(w);
		meas(w);
		chk(near(w, 23), 1);
		@(posedge clock);
		slow <= 4'hA;
		waitst(3);
		waitst(0);
		meas(w);
		@(posedge clock);
		slow <= 4'hB;
		waitst(1);
		chk(gate_drive, 1'b0);
		$display("test burst and restart done");
		@(posedge clock);
		slow <= 4'h0;
		repeat (6) tick();
		chk(status, 5'h00);
		@(posedge clock);
		slow <= 4'h8;
		waitst(4);
		meas(w);
		chk(w <= 10, 1);
		$display("test second start done");
		end_of_test();
	end
endmodule
